// ==== bstp_pkg.sv ====
// Package for the boundary-scan test port: states, instructions, carriers and constants
// Operation
// R01 - The port samples test mode select on every rising test clock edge to steer the controller.
// R02 - Test data input is shifted into the selected register on the rising test clock edge.
// R03 - Test data output changes on the falling test clock edge so the tester samples it next rise.
// R04 - The test data output is undriven except while a shift state scans data out.
// R05 - A low test reset forces the port into its reset condition without needing the test clock.
// R06 - With the test clock idle low, every test-logic storage element holds its value.
// R07 - The board holds test reset low whenever boundary-scan testing is not in use.
// R08 - The controller follows the sixteen-state boundary-scan machine, walked by the tester.
package bstp_pkg;

   // ****************************************
   // Controller states
   // ****************************************
   typedef enum logic [3:0] {
      BSTP_RESET, BSTP_IDLE,
      BSTP_SEL_DR, BSTP_CAP_DR, BSTP_SH_DR, BSTP_EX1_DR,
      BSTP_PAUSE_DR, BSTP_EX2_DR, BSTP_UPD_DR,
      BSTP_SEL_IR, BSTP_CAP_IR, BSTP_SH_IR, BSTP_EX1_IR,
      BSTP_PAUSE_IR, BSTP_EX2_IR, BSTP_UPD_IR
   } bstp_state_t;

   // ****************************************
   // Sizes, instruction codes and reset values
   // ****************************************
   localparam int          IR_W        = 4;
   localparam int          ID_W        = 32;
   localparam logic [3:0]  IR_CAPTURE  = 4'h1;   // Fixed capture pattern, lsbs 01
   localparam logic [3:0]  IR_IDCODE   = 4'h2;
   localparam logic [3:0]  IR_SAMPLE   = 4'h3;
   localparam logic [3:0]  IR_BYPASS   = 4'hf;
   localparam logic [3:0]  IR_RESET    = IR_IDCODE;
   // Identification word: value is arbitrary, bit 0 set as the standard needs
   localparam logic [31:0] ID_DEFAULT  = 32'h0a5a_5001;

   // Status carried from test clock domain to system clock domain
   typedef struct packed {
      logic        in_reset;
      logic        scanning;
   } bstp_stat_t;

endpackage : bstp_pkg

// ==== bstp_sync.sv ====
// Two flip-flop level synchroniser into the system clock domain
`timescale 1ns/1ps
module bstp_sync #(
   parameter int W = 2
) (
   // Clock and reset
   input  wire logic         mclk,
   input  wire logic         rst,
   // Data
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] meta_q;

   // First stage feeds only the second
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         meta_q <= '0;
         dout   <= '0;
      end else begin
         meta_q <= din;
         dout   <= meta_q;
      end
   end
endmodule : bstp_sync

// ==== bstp_tester.sv ====
// Boundary-scan tester model driving the test port pins
`timescale 1ns/1ps
module bstp_tester (
   // Pins driven by the tester
   output logic      tck,
   output logic      trst_n,
   output logic      tms,
   output logic      tdi,
   // Pins watched
   input  wire logic tdo_o,
   input  wire logic tdo_oe
);
   // Clock parked low; reset pulled low just after time zero so the port sees the edge
   initial begin
      tck = 1'b0;
      trst_n = 1'b1;
      tms = 1'b1;
      tdi = 1'b1;
      #1 trst_n = 1'b0;
   end
   // Drive the test reset pin; low parks the port as the board does when unused
   task automatic set_reset(input logic v);
      trst_n = v;
   endtask : set_reset
   // One test clock, pins set while low; q is tdo just before the rise
   task automatic step(input logic m, input logic d, output logic [1:0] q);
      tms = m;
      tdi = d;
      #16 q = {tdo_oe, tdo_o};
      tck = 1'b1;
      #16 tck = 1'b0;
   endtask : step
   // Walk n tms values, lsb first, data line left high
   task automatic walk(input logic [7:0] s, input int n);
      logic [1:0] q;
      for (int i = 0; i < n; i++) step(s[i], 1'b1, q);
   endtask : walk
   // Shift n bits lsb first, leaving on the last; ok drops if tdo was undriven
   task automatic shift(input logic [31:0] din, input int n, output logic [31:0] dout,
                        output logic ok);
      logic [1:0] q;
      dout = '0;
      ok = 1'b1;
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], q);
         dout[i] = q[0];
         ok = ok & q[1];
      end
      tdi = 1'b1;
   endtask : shift
endmodule : bstp_tester

// ==== bstp_top.sv ====
// Boundary-scan test access port with controller, instruction and data registers
`timescale 1ns/1ps
module bstp_top #(
   parameter logic [31:0] ID_WORD = bstp_pkg::ID_DEFAULT,
   parameter int          SAMP_W  = 8
) (
   // System clock and reset
   input  wire logic              mclk,
   input  wire logic              rst,
   // Test port pins
   input  wire logic              tck,
   input  wire logic              trst_n,
   input  wire logic              tms,
   input  wire logic              tdi,
   output logic                   tdo_o,
   output logic                   tdo_oe,
   // Core side
   input  wire logic [SAMP_W-1:0] core_pins,
   output logic [SAMP_W-1:0]      samp_q,
   output logic                   tap_in_reset,
   output logic                   tap_scanning
);
   bstp_pkg::bstp_state_t               st_q;
   bstp_pkg::bstp_state_t               st_d;
   logic [bstp_pkg::IR_W-1:0]           ir_sh_q;
   logic [bstp_pkg::IR_W-1:0]           ir_q;
   logic [bstp_pkg::ID_W-1:0]           id_sh_q;
   logic [SAMP_W-1:0]                   bs_sh_q;
   logic                                byp_q;
   logic                                tdo_bit;
   logic                                shift_any;
   bstp_pkg::bstp_stat_t                stat_tck;
   bstp_pkg::bstp_stat_t                stat_sys;
   logic [SAMP_W-1:0]                   pins_meta_q;
   logic [SAMP_W-1:0]                   pins_q;
   logic                                in_rst_q;

   // ****************************************
   // State decodes
   // ****************************************
   // True in either shift state, where data moves and the output drives
   function automatic logic is_shift(input bstp_pkg::bstp_state_t s);
      return (s == bstp_pkg::BSTP_SH_DR) || (s == bstp_pkg::BSTP_SH_IR);
   endfunction : is_shift

   // ****************************************
   // Controller next state
   // ****************************************
   always_comb begin
      st_d = st_q;
      unique case (st_q)                                          // R08
         bstp_pkg::BSTP_RESET:    st_d = tms ? bstp_pkg::BSTP_RESET   : bstp_pkg::BSTP_IDLE;
         bstp_pkg::BSTP_IDLE:     st_d = tms ? bstp_pkg::BSTP_SEL_DR  : bstp_pkg::BSTP_IDLE;
         bstp_pkg::BSTP_SEL_DR:   st_d = tms ? bstp_pkg::BSTP_SEL_IR  : bstp_pkg::BSTP_CAP_DR;
         bstp_pkg::BSTP_CAP_DR:   st_d = tms ? bstp_pkg::BSTP_EX1_DR  : bstp_pkg::BSTP_SH_DR;
         bstp_pkg::BSTP_SH_DR:    st_d = tms ? bstp_pkg::BSTP_EX1_DR  : bstp_pkg::BSTP_SH_DR;
         bstp_pkg::BSTP_EX1_DR:   st_d = tms ? bstp_pkg::BSTP_UPD_DR  : bstp_pkg::BSTP_PAUSE_DR;
         bstp_pkg::BSTP_PAUSE_DR: st_d = tms ? bstp_pkg::BSTP_EX2_DR  : bstp_pkg::BSTP_PAUSE_DR;
         bstp_pkg::BSTP_EX2_DR:   st_d = tms ? bstp_pkg::BSTP_UPD_DR  : bstp_pkg::BSTP_SH_DR;
         bstp_pkg::BSTP_UPD_DR:   st_d = tms ? bstp_pkg::BSTP_SEL_DR  : bstp_pkg::BSTP_IDLE;
         bstp_pkg::BSTP_SEL_IR:   st_d = tms ? bstp_pkg::BSTP_RESET   : bstp_pkg::BSTP_CAP_IR;
         bstp_pkg::BSTP_CAP_IR:   st_d = tms ? bstp_pkg::BSTP_EX1_IR  : bstp_pkg::BSTP_SH_IR;
         bstp_pkg::BSTP_SH_IR:    st_d = tms ? bstp_pkg::BSTP_EX1_IR  : bstp_pkg::BSTP_SH_IR;
         bstp_pkg::BSTP_EX1_IR:   st_d = tms ? bstp_pkg::BSTP_UPD_IR  : bstp_pkg::BSTP_PAUSE_IR;
         bstp_pkg::BSTP_PAUSE_IR: st_d = tms ? bstp_pkg::BSTP_EX2_IR  : bstp_pkg::BSTP_PAUSE_IR;
         bstp_pkg::BSTP_EX2_IR:   st_d = tms ? bstp_pkg::BSTP_UPD_IR  : bstp_pkg::BSTP_SH_IR;
         bstp_pkg::BSTP_UPD_IR:   st_d = tms ? bstp_pkg::BSTP_SEL_DR  : bstp_pkg::BSTP_IDLE;
      endcase
   end

   // Controller state, sampled on rising test clock, held while the clock idles
   always_ff @(posedge tck or negedge trst_n) begin
      if (!trst_n) begin                                          // R05
         st_q <= bstp_pkg::BSTP_RESET;
      end else begin
         st_q <= st_d;                                            // R01 R06
      end
   end

   // ****************************************
   // Instruction register
   // ****************************************
   // Instruction shift stage: fixed pattern at capture, then serial load
   always_ff @(posedge tck or negedge trst_n) begin
      if (!trst_n) begin
         ir_sh_q <= '0;
      end else if (st_q == bstp_pkg::BSTP_CAP_IR) begin
         ir_sh_q <= bstp_pkg::IR_CAPTURE;
      end else if (st_q == bstp_pkg::BSTP_SH_IR) begin
         ir_sh_q <= {tdi, ir_sh_q[bstp_pkg::IR_W-1:1]};           // R02
      end
   end

   // Active instruction: reloaded in the reset state, taken from the stage at update
   always_ff @(posedge tck or negedge trst_n) begin
      if (!trst_n) begin
         ir_q <= bstp_pkg::IR_RESET;                              // R05
      end else if (st_q == bstp_pkg::BSTP_RESET) begin
         ir_q <= bstp_pkg::IR_RESET;
      end else if (st_q == bstp_pkg::BSTP_UPD_IR) begin
         ir_q <= ir_sh_q;
      end
   end

   // ****************************************
   // Core pin synchroniser
   // ****************************************
   // Core pins come from another domain, so two stages precede the capture
   always_ff @(posedge tck or negedge trst_n) begin
      if (!trst_n) begin
         pins_meta_q <= '0;
         pins_q      <= '0;
      end else begin
         pins_meta_q <= core_pins;
         pins_q      <= pins_meta_q;
      end
   end

   // ****************************************
   // Data registers: identification, bypass, sample
   // ****************************************
   // Identification word: loaded at capture, shifted lsb first
   always_ff @(posedge tck or negedge trst_n) begin
      if (!trst_n) begin
         id_sh_q <= '0;
      end else if (st_q == bstp_pkg::BSTP_CAP_DR) begin
         id_sh_q <= ID_WORD;
      end else if (st_q == bstp_pkg::BSTP_SH_DR) begin
         id_sh_q <= {tdi, id_sh_q[bstp_pkg::ID_W-1:1]};           // R02
      end
   end

   // Sample stage: takes the synchronised pins at capture
   always_ff @(posedge tck or negedge trst_n) begin
      if (!trst_n) begin
         bs_sh_q <= '0;
      end else if (st_q == bstp_pkg::BSTP_CAP_DR) begin
         bs_sh_q <= pins_q;
      end else if (st_q == bstp_pkg::BSTP_SH_DR) begin
         bs_sh_q <= {tdi, bs_sh_q[SAMP_W-1:1]};                   // R02
      end
   end

   // Bypass stage: cleared at capture so the first bit out is zero
   always_ff @(posedge tck or negedge trst_n) begin
      if (!trst_n) begin
         byp_q <= 1'b0;
      end else if (st_q == bstp_pkg::BSTP_CAP_DR) begin
         byp_q <= 1'b0;
      end else if (st_q == bstp_pkg::BSTP_SH_DR) begin
         byp_q <= tdi;                                            // R02
      end
   end

   // Sample output: loaded at update under the sample instruction only
   always_ff @(posedge tck or negedge trst_n) begin
      if (!trst_n) begin
         samp_q <= '0;                                            // R05
      end else if (st_q == bstp_pkg::BSTP_UPD_DR && ir_q == bstp_pkg::IR_SAMPLE) begin
         samp_q <= bs_sh_q;
      end
   end

   // Select the bit that leaves the chip
   always_comb begin
      shift_any = is_shift(st_q);
      if (st_q == bstp_pkg::BSTP_SH_IR) begin
         tdo_bit = ir_sh_q[0];
      end else begin
         unique case (ir_q)
            bstp_pkg::IR_IDCODE: tdo_bit = id_sh_q[0];
            bstp_pkg::IR_SAMPLE: tdo_bit = bs_sh_q[0];
            default:             tdo_bit = byp_q;
         endcase
      end
   end

   // ****************************************
   // Output driver on the falling test clock
   // ****************************************
   always_ff @(negedge tck or negedge trst_n) begin
      if (!trst_n) begin
         tdo_o  <= 1'b0;
         tdo_oe <= 1'b0;                                          // R04 R05
      end else begin
         tdo_o  <= tdo_bit;                                       // R03
         tdo_oe <= shift_any;                                     // R04
      end
   end

   // ****************************************
   // Status crossing to the system clock
   // ****************************************
   // Reset-state flag retimed on the falling test clock, so no decode glitch crosses
   always_ff @(negedge tck or negedge trst_n) begin
      if (!trst_n) begin
         in_rst_q <= 1'b1;                                        // R05
      end else begin
         in_rst_q <= (st_q == bstp_pkg::BSTP_RESET);
      end
   end

   // Both crossing bits come straight from flip-flops
   always_comb begin
      stat_tck.in_reset = in_rst_q;
      stat_tck.scanning = tdo_oe;
   end

   bstp_sync #(
      .W (2)
   ) u_sync (
      .mclk (mclk),
      .rst  (rst),
      .din  (stat_tck),
      .dout (stat_sys)
   );

   // Registered status flags in the system domain
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         tap_in_reset <= 1'b1;
         tap_scanning <= 1'b0;
      end else begin
         tap_in_reset <= stat_sys.in_reset;
         tap_scanning <= stat_sys.scanning;
      end
   end
endmodule : bstp_top

// ==== bstp_top_properties.sv ====
// Checker of test port pin timing and status flags
`timescale 1ns/1ps
module bstp_top_properties #(parameter int SAMP_W = 8) (
   // Watched pins and flags
   input wire logic              mclk, rst, tck, trst_n, tms, tdi, tdo_o, tdo_oe,
   input wire logic [SAMP_W-1:0] core_pins, samp_q,
   input wire logic              tap_in_reset, tap_scanning
);
   // Test clock checks wait for the system reset to end, away from time zero
   logic armed_q = 1'b0;
   always_ff @(posedge mclk) armed_q <= !rst;
   // Tdo pins as seen just before each rising test clock
   logic [1:0] rise_q;
   always_ff @(posedge tck or negedge trst_n) begin
      if (!trst_n) rise_q <= 2'b00;
      else rise_q <= {tdo_oe, tdo_o};
   end
   property p_fall;
      @(negedge tck) disable iff (!trst_n || !armed_q) {tdo_oe, tdo_o} == rise_q;
   endproperty
   a_fall: assert property (p_fall) else $error("tdo moved on rise");
   property p_exit;
      @(posedge tck) disable iff (!trst_n || !armed_q) tms |=> !tdo_oe;
   endproperty
   a_exit: assert property (p_exit) else $error("tdo driven off shift");
   property p_enter;
      // Shift is entered from capture or from the second exit, so only the last bit is fixed
      @(posedge tck) disable iff (!trst_n || !armed_q) $rose(tdo_oe) |-> !$past(tms);
   endproperty
   a_enter: assert property (p_enter) else $error("shift entered wrongly");
   property p_trst; @(posedge mclk) disable iff (rst) !trst_n |-> !tdo_oe && samp_q == '0;
   endproperty
   a_trst: assert property (p_trst) else $error("test reset ignored");
   property p_inrst; @(posedge mclk) disable iff (rst) (!trst_n) [*4] |-> tap_in_reset;
   endproperty
   a_inrst: assert property (p_inrst) else $error("reset flag low");
   property p_idle;
      @(posedge mclk) disable iff (rst) (!tck && trst_n) [*4] |-> $stable({tdo_oe, tdo_o, samp_q});
   endproperty
   a_idle: assert property (p_idle) else $error("state moved while idle");
   property p_scan; @(posedge mclk) disable iff (rst) tdo_oe [*5] |-> tap_scanning; endproperty
   a_scan: assert property (p_scan) else $error("scan flag low");
   // Main scenarios reached
   c_shift: cover property (@(posedge tck) $rose(tdo_oe));
   c_trst: cover property (@(posedge mclk) $fell(trst_n));
   c_samp: cover property (@(posedge mclk) $changed(samp_q));
endmodule : bstp_top_properties
bind bstp_top bstp_top_properties #(.SAMP_W(SAMP_W)) chk_u (.mclk(mclk), .rst(rst), .tck(tck),
   .trst_n(trst_n), .tms(tms), .tdi(tdi), .tdo_o(tdo_o), .tdo_oe(tdo_oe), .core_pins(core_pins),
   .samp_q(samp_q), .tap_in_reset(tap_in_reset), .tap_scanning(tap_scanning));

// ==== bstp_top_tb.sv ====
// Self-checking bench for the boundary-scan test port
`timescale 1ns/1ps
module bstp_top_tb;
   logic        mclk, rst, tck, trst_n, tms, tdi, tdo_o, tdo_oe, tap_in_reset, tap_scanning, ok;
   logic [7:0]  core_pins, samp_q;
   logic [31:0] dout;
   int          miscompares = 0;
   int          tests_run = 0;
   int          cycles = 0;
   bstp_top #(.SAMP_W(8)) dut_u (.mclk(mclk), .rst(rst), .tck(tck), .trst_n(trst_n), .tms(tms),
      .tdi(tdi), .tdo_o(tdo_o), .tdo_oe(tdo_oe), .core_pins(core_pins), .samp_q(samp_q),
      .tap_in_reset(tap_in_reset), .tap_scanning(tap_scanning));
   bstp_tester tst_u (.tck(tck), .trst_n(trst_n), .tms(tms), .tdi(tdi), .tdo_o(tdo_o),
      .tdo_oe(tdo_oe));
   // System clock and hang limit
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         test_done();
      end
   end
   task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp
   task automatic test_done();
      if (miscompares == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : test_done
   // Identification word read straight after reset, then back to idle
   task automatic t_idcode();
      cmp("in_reset", 1, 32'(tap_in_reset));
      tst_u.walk(8'h02, 4);
      tst_u.shift(32'h0, 32, dout, ok);
      cmp("idcode", bstp_pkg::ID_DEFAULT, dout);
      cmp("oe_shift", 1, 32'(ok));
      tst_u.walk(8'h01, 2);
      repeat (6) @(posedge mclk);
      cmp("oe_idle", 0, 32'(tdo_oe));
      cmp("scan_idle", 0, 32'(tap_scanning));
      cmp("in_reset", 0, 32'(tap_in_reset));
   endtask : t_idcode
   // Load an instruction from idle, checking the captured pattern
   task automatic load_ir(input logic [3:0] code);
      tst_u.walk(8'h03, 4);
      tst_u.shift(32'(code), 4, dout, ok);
      cmp("ir_capture", 32'(bstp_pkg::IR_CAPTURE), dout);
      tst_u.walk(8'h01, 2);
   endtask : load_ir
   // Bypass delays data by one stage, leading with a zero
   task automatic t_bypass();
      load_ir(bstp_pkg::IR_BYPASS);
      tst_u.walk(8'h01, 3);
      tst_u.shift(32'hb5, 8, dout, ok);
      cmp("bypass", 32'h6a, dout);
      tst_u.walk(8'h01, 2);
   endtask : t_bypass
   // Sample captures the core pins, update loads the shifted word, idle keeps it
   task automatic t_sample();
      load_ir(bstp_pkg::IR_SAMPLE);
      tst_u.walk(8'h01, 3);
      tst_u.shift(32'h3c, 8, dout, ok);
      cmp("sample_cap", 32'ha7, dout);
      tst_u.walk(8'h01, 2);
      repeat (12) @(posedge mclk);
      cmp("samp_q", 32'h3c, 32'(samp_q));
   endtask : t_sample
   // Five ones reach reset; parked in shift, then test reset clears at once
   task automatic t_resets();
      tst_u.walk(8'h1f, 5);
      repeat (6) @(posedge mclk);
      cmp("tms_reset", 1, 32'(tap_in_reset));
      tst_u.walk(8'h02, 4);
      repeat (6) @(posedge mclk);
      cmp("oe_on", 1, 32'(tdo_oe));
      cmp("scan_flag", 1, 32'(tap_scanning));
      tst_u.set_reset(1'b0);
      #1 cmp("oe_trst", 0, 32'(tdo_oe));
      cmp("samp_trst", 0, 32'(samp_q));
      repeat (6) @(posedge mclk);
      cmp("trst_flag", 1, 32'(tap_in_reset));
      cmp("scan_trst", 0, 32'(tap_scanning));
   endtask : t_resets
   // Main sequence
   initial begin
      rst = 1'b1;
      core_pins = 8'ha7;
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      repeat (5) @(posedge mclk);
      tst_u.set_reset(1'b1);
      @(posedge mclk);
      t_idcode();
      t_bypass();
      t_sample();
      t_resets();
      test_done();
   end
endmodule : bstp_top_tb
